// File: hdl/sleep_gate_ctrl.sv
// Contract
// [R01] gate bit one clocks unit, zero stops
// [R02] access to gated unit gives bus fault
// [R03] register resets to all zeros
// [R04] sleep gating register at 0x118
// [R05] sleep gating applies only with auto select
// [R06] bit 30 gates ethernet phy
// [R07] bit 28 gates ethernet mac
// [R08] bits 7..0 gate ports h..a
// [R09] reserved bits read zero, ignore writes
// [R10] software enables every needed unit
// [R11] otherwise follow run gating, glitch-free enables
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "sleep_gate_defs.svh"

module sleep_gate_ctrl (
  input  wire logic                      clk,                // system clock, 50 MHz
  input  wire logic                      rstn,               // async reset, active low
  input  wire sleep_gate_pkg::addr_t     addr,               // register byte address
  input  wire sleep_gate_pkg::word_t     wdata,              // write data
  input  wire logic                      wr_en,              // write strobe
  input  wire logic                      rd_en,              // read strobe
  output sleep_gate_pkg::word_t          rdata,              // read data, cycle after rd_en
  input  wire logic                      auto_gating_select, // automatic gating select
  input  wire logic                      sleep_active,       // core is in sleep
  input  wire logic                      deep_sleep_active,  // core is in deep sleep
  input  wire sleep_gate_pkg::word_t     run_gate_reg,       // run-mode gating value
  input  wire sleep_gate_pkg::word_t     deep_sleep_gate_reg,// deep-sleep gating value
  input  wire logic                      acc_req,            // access strobe to a unit
  input  wire sleep_gate_pkg::unit_idx_t acc_unit,           // addressed unit
  output logic                           acc_grant,          // access completes
  output logic                           acc_fault,          // bus fault answer
  output sleep_gate_pkg::unit_vec_t      unit_clk_en,        // per-unit clock enables
  output logic                           irq                 // level interrupt
);
  import sleep_gate_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  word_t                sleep_gate_q;
  word_t                sleep_gate_d;
  gate_mode_t           mode_q;
  gate_mode_t           mode_d;
  logic [`IRQ_W-1:0]    status_q;
  logic [`IRQ_W-1:0]    status_d;
  logic [`IRQ_W-1:0]    mask_q;
  logic [`IRQ_W-1:0]    mask_d;
  logic                 irq_d;
  word_t                rdata_d;
  word_t                sel_gate;
  unit_vec_t            gate_req;
  unit_idx_t            fault_unit;
  logic                 fault_evt;
  logic                 mode_evt;
  logic                 hit_sleep;
  logic                 hit_status;
  logic                 hit_mask;
  logic                 status_wr;
  logic                 mask_wr;
  logic [`IRQ_W-1:0]    status_set;
  word_t                run_gate_clean;
  word_t                deep_gate_clean;
  word_t                rd_value;

  // ************************************************************
  // address decode
  // ************************************************************
  // [R04] sleep register offset
  always_comb begin
    hit_sleep  = (addr == `SLEEP_GATE_OFS);
    hit_status = (addr == `IRQ_STATUS_OFS);
    hit_mask   = (addr == `IRQ_MASK_OFS);
  end

  // ************************************************************
  // sleep gating register
  // ************************************************************
  // [R09] reserved bits masked
  always_comb begin
    sleep_gate_d = sleep_gate_q;
    if (wr_en && hit_sleep) begin
      sleep_gate_d = wdata & `GATE_WR_MASK;
    end
  end

  // [R03] all gates off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_gate_q <= `GATE_RESET;
    end else begin
      sleep_gate_q <= sleep_gate_d;
    end
  end

  // ************************************************************
  // gating mode
  // ************************************************************
  // [R05] sleep needs auto select
  always_comb begin
    mode_d = MODE_RUN;
    case (mode_q)
      MODE_RUN, MODE_SLEEP, MODE_DEEP: begin
        if (auto_gating_select && deep_sleep_active) begin
          mode_d = MODE_DEEP;
        end else if (auto_gating_select && sleep_active) begin
          mode_d = MODE_SLEEP;
        end else begin
          // [R11] fall back to run
          mode_d = MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ************************************************************
  // companion gating inputs
  // ************************************************************
  // reserved bits of the run and deep-sleep words are dropped here, so a
  // stray one there can never reach a unit that does not exist
  always_comb begin
    run_gate_clean  = run_gate_reg & `GATE_WR_MASK;
    deep_gate_clean = deep_sleep_gate_reg & `GATE_WR_MASK;
  end

  // ************************************************************
  // gate selection
  // ************************************************************
  always_comb begin
    case (mode_q)
      MODE_SLEEP: begin
        sel_gate = sleep_gate_q;
      end
      MODE_DEEP: begin
        sel_gate = deep_gate_clean;
      end
      default: begin
        sel_gate = run_gate_clean;
      end
    endcase
  end

  // units 0..7 are ports a..h, 8 the mac, 9 the phy
  always_comb begin
    // [R08] port gates
    gate_req[7:0] = sel_gate[`PORT_H_GATE_BIT:`PORT_A_GATE_BIT];
    // [R07] mac gate
    gate_req[`UNIT_MAC_IDX] = sel_gate[`MAC_GATE_BIT];
    // [R06] phy gate
    gate_req[`UNIT_PHY_IDX] = sel_gate[`PHY_GATE_BIT];
  end

  // ************************************************************
  // per-unit enable cells
  // ************************************************************
  // [R01] enable follows bit
  // [R11] glitch-free enable cell
  // [R10] nothing runs until set
  for (genvar u = 0; u < `NUM_UNITS; u++) begin : g_cell
    clk_gate_cell u_cell (
      .clk    (clk),
      .rstn   (rstn),
      .en_req (gate_req[u]),
      .clk_en (unit_clk_en[u])
    );
  end

  // ************************************************************
  // unit access checking
  // ************************************************************
  // judged against the live enables, so an access in the cycle a gate
  // turns on still faults; software must wait one cycle after enabling
  // [R02] fault on gated access
  unit_access_check u_check (
    .clk          (clk),
    .rstn         (rstn),
    .acc_req      (acc_req),
    .acc_unit     (acc_unit),
    .gate_en      (unit_clk_en),
    .grant_q      (acc_grant),
    .fault_q      (acc_fault),
    .fault_unit_q (fault_unit)
  );

  // ************************************************************
  // interrupt events
  // ************************************************************
  // a fault is counted on the cycle its answer leaves the block
  always_comb begin
    fault_evt                  = acc_fault;
    mode_evt                   = (mode_d != mode_q);
    status_wr                  = wr_en && hit_status;
    mask_wr                    = wr_en && hit_mask;
    status_set                 = `IRQ_RESET;
    status_set[`IRQ_FAULT_BIT] = fault_evt;
    status_set[`IRQ_MODE_BIT]  = mode_evt;
  end

  // ************************************************************
  // interrupt status, write one to clear
  // ************************************************************
  // set wins over a write-one clear in the same cycle, so no event is lost
  always_comb begin
    status_d = status_q;
    if (status_wr) begin
      status_d = status_q & ~wdata[`IRQ_W-1:0];
    end
    status_d = status_d | status_set;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= `IRQ_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // ************************************************************
  // interrupt mask
  // ************************************************************
  always_comb begin
    mask_d = mask_q;
    if (mask_wr) begin
      mask_d = wdata[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= `IRQ_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ************************************************************
  // interrupt line
  // ************************************************************
  // built from the next values so irq moves on the same edge as status
  always_comb begin
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // ************************************************************
  // register read
  // ************************************************************
  // unmapped addresses read as zero
  // [R09] reserved read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (addr)
      `SLEEP_GATE_OFS: begin
        rd_value = sleep_gate_q & `GATE_WR_MASK;
      end
      `IRQ_STATUS_OFS: begin
        rd_value = {30'h0000_0000, status_q};
      end
      `IRQ_MASK_OFS: begin
        rd_value = {30'h0000_0000, mask_q};
      end
      `FAULT_INFO_OFS: begin
        rd_value = {28'h000_0000, fault_unit};
      end
      `GATE_STATE_OFS: begin
        rd_value = {20'h0_0000, mode_q, unit_clk_en};
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // rdata is zero outside the cycle after a read, so no stale value lingers
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_en) begin
      rdata_d = rd_value;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rdata_d;
    end
  end

endmodule : sleep_gate_ctrl

// File: hdl/sleep_gate_defs.svh
`ifndef SLEEP_GATE_DEFS_SVH
`define SLEEP_GATE_DEFS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define RUN_GATE_OFS      12'h108
`define SLEEP_GATE_OFS    12'h118
`define DEEP_GATE_OFS     12'h128
`define IRQ_STATUS_OFS    12'h200
`define IRQ_MASK_OFS      12'h204
`define FAULT_INFO_OFS    12'h208
`define GATE_STATE_OFS    12'h20c

// ************************************************************
// gate register layout
// ************************************************************
`define GATE_RESET        32'h0000_0000
`define GATE_WR_MASK      32'h5000_00ff
`define PHY_GATE_BIT      30
`define MAC_GATE_BIT      28
`define PORT_H_GATE_BIT   7
`define PORT_A_GATE_BIT   0

// ************************************************************
// interrupt status layout
// ************************************************************
`define IRQ_W             2
`define IRQ_FAULT_BIT     0
`define IRQ_MODE_BIT      1
`define IRQ_RESET         2'h0

// ************************************************************
// unit numbering on the access port
// ************************************************************
`define NUM_UNITS         10
`define UNIT_IDX_W        4
`define UNIT_MAC_IDX      4'h8
`define UNIT_PHY_IDX      4'h9

`endif

// File: hdl/sleep_gate_pkg.sv
package sleep_gate_pkg;

  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
  typedef logic [9:0]  unit_vec_t;
  typedef logic [3:0]  unit_idx_t;

  // which gating register currently steers the clock enables
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } gate_mode_t;

endpackage : sleep_gate_pkg

// File: hdl/clk_gate_cell.sv
`timescale 1ns/1ps

module clk_gate_cell (
  input  wire logic clk,     // system clock
  input  wire logic rstn,    // async reset, active low
  input  wire logic en_req,  // requested enable
  output logic      clk_en   // registered clock enable
);

  logic en_d;

  // registering the enable keeps it free of combinational glitches
  always_comb begin
    en_d = en_req;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_en <= 1'b0;
    end else begin
      clk_en <= en_d;
    end
  end

endmodule : clk_gate_cell

// File: hdl/unit_access_check.sv
`timescale 1ns/1ps
`include "sleep_gate_defs.svh"

module unit_access_check (
  input  wire logic                     clk,         // system clock
  input  wire logic                     rstn,        // async reset, active low
  input  wire logic                     acc_req,     // access strobe to a unit
  input  wire sleep_gate_pkg::unit_idx_t acc_unit,   // addressed unit
  input  wire sleep_gate_pkg::unit_vec_t gate_en,    // live clock enables
  output logic                          grant_q,     // access completes
  output logic                          fault_q,     // access faults
  output sleep_gate_pkg::unit_idx_t     fault_unit_q // last faulting unit
);
  import sleep_gate_pkg::*;

  logic      grant_d;
  logic      fault_d;
  unit_idx_t fault_unit_d;
  logic      unit_on;
  logic      unit_valid;

  // [R02] fault gated unit
  always_comb begin
    unit_valid   = (acc_unit < 4'(`NUM_UNITS));
    unit_on      = unit_valid ? gate_en[acc_unit] : 1'b0;
    grant_d      = acc_req & unit_on;
    fault_d      = acc_req & ~unit_on;
    fault_unit_d = fault_d ? acc_unit : fault_unit_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grant_q      <= 1'b0;
      fault_q      <= 1'b0;
      fault_unit_q <= 4'h0;
    end else begin
      grant_q      <= grant_d;
      fault_q      <= fault_d;
      fault_unit_q <= fault_unit_d;
    end
  end

endmodule : unit_access_check

// File: test/sleep_gate_ctrl_properties.sv
`timescale 1ns/1ps
`include "sleep_gate_defs.svh"
module sleep_gate_ctrl_props (
  input wire logic                      clk,                // system clock
  input wire logic                      rstn,               // async reset
  input wire sleep_gate_pkg::addr_t     addr,               // address
  input wire logic                      wr_en,              // write strobe
  input wire logic                      rd_en,              // read strobe
  input wire sleep_gate_pkg::word_t     rdata,              // read data
  input wire logic                      auto_gating_select, // auto select
  input wire logic                      sleep_active,       // sleep
  input wire logic                      deep_sleep_active,  // deep sleep
  input wire sleep_gate_pkg::word_t     run_gate_reg,       // run gating
  input wire sleep_gate_pkg::word_t     deep_sleep_gate_reg,// deep gating
  input wire logic                      acc_req,            // access strobe
  input wire sleep_gate_pkg::unit_idx_t acc_unit,           // unit
  input wire logic                      acc_grant,          // completed
  input wire logic                      acc_fault,          // fault
  input wire sleep_gate_pkg::unit_vec_t unit_clk_en         // enables
);
  import sleep_gate_pkg::*;
  function automatic unit_vec_t gmap(input word_t w);
    return {w[30], w[28], w[7:0]};
  endfunction : gmap
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ********
  // properties
  // ********
  reserved_read_zero_a: assert property ($past(rd_en) && $past(addr) == `SLEEP_GATE_OFS
    |-> (rdata & ~`GATE_WR_MASK) == 32'h0) else $error("reserved bits read nonzero");
  gated_fault_a: assert property (acc_req && acc_unit < 4'ha && !unit_clk_en[acc_unit]
    |=> acc_fault && !acc_grant) else $error("gated access not faulted");
  open_grant_a: assert property (acc_req && acc_unit < 4'ha && unit_clk_en[acc_unit]
    |=> acc_grant && !acc_fault) else $error("enabled access not granted");
  range_fault_a: assert property (acc_req && acc_unit > 4'h9 |=> acc_fault)
    else $error("bad unit not faulted");
  no_answer_a: assert property (!acc_req |=> !acc_grant && !acc_fault)
    else $error("answer without request");
  run_follow_a: assert property (!$past(auto_gating_select) && !$past(auto_gating_select, 2)
    && !$past(auto_gating_select, 3) && $past(run_gate_reg) == $past(run_gate_reg, 3)
    && $past(run_gate_reg, 2) == $past(run_gate_reg, 3) |-> unit_clk_en == gmap($past(run_gate_reg)))
    else $error("enables not from run gating");
  deep_follow_a: assert property ($past(auto_gating_select && deep_sleep_active)
    && $past(auto_gating_select && deep_sleep_active, 2) && $past(auto_gating_select && deep_sleep_active, 3)
    && $past(deep_sleep_gate_reg) == $past(deep_sleep_gate_reg, 2)
    |-> unit_clk_en == gmap($past(deep_sleep_gate_reg))) else $error("enables not from deep gating");
  sleep_hold_a: assert property ($past(auto_gating_select && sleep_active && !deep_sleep_active)
    && $past(auto_gating_select && sleep_active && !deep_sleep_active, 2)
    && $past(auto_gating_select && sleep_active && !deep_sleep_active, 3) && !$past(wr_en)
    && !$past(wr_en, 2) && !$past(wr_en, 3) |-> $stable(unit_clk_en)) else $error("sleep enables moved");
endmodule : sleep_gate_ctrl_props

bind sleep_gate_ctrl sleep_gate_ctrl_props u_props (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .auto_gating_select(auto_gating_select), .sleep_active(sleep_active),
  .deep_sleep_active(deep_sleep_active), .run_gate_reg(run_gate_reg), .deep_sleep_gate_reg(deep_sleep_gate_reg),
  .acc_req(acc_req), .acc_unit(acc_unit), .acc_grant(acc_grant), .acc_fault(acc_fault), .unit_clk_en(unit_clk_en));

// File: test/sleep_mode_clock_gating_tb_top.sv
`timescale 1ns/1ps
`include "sleep_gate_defs.svh"
module sleep_mode_clock_gating_tb_top;
  import sleep_gate_pkg::*;
  logic      clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, acc_req = 1'b0;
  logic      sel = 1'b0, slp = 1'b0, deep = 1'b0, acc_grant, acc_fault, irq;
  addr_t     addr = 12'h0;
  word_t     wdata = 32'h0, rdata, run_q = 32'h0, deep_q = 32'h0;
  unit_idx_t acc_unit = 4'h0;
  unit_vec_t unit_clk_en;
  int        fails = 0, n_checks = 0;
  always #10 clk = ~clk;
  sleep_gate_ctrl DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .auto_gating_select(sel), .sleep_active(slp), .deep_sleep_active(deep),
    .run_gate_reg(run_q), .deep_sleep_gate_reg(deep_q), .acc_req(acc_req), .acc_unit(acc_unit),
    .acc_grant(acc_grant), .acc_fault(acc_fault), .unit_clk_en(unit_clk_en), .irq(irq));
  // ********
  // helpers
  // ********
  task check(input word_t seen, input word_t exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input addr_t a, input word_t d);
    @(posedge clk); addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk); wr_en <= 1'b0;
  endtask : wr
  task rd_chk(input addr_t a, input word_t exp);
    @(posedge clk); addr <= a; rd_en <= 1'b1;
    @(posedge clk); rd_en <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk
  task acc(input unit_idx_t u, input logic f);
    @(posedge clk); acc_unit <= u; acc_req <= 1'b1;
    @(posedge clk); acc_req <= 1'b0;
    #1 check({acc_grant, acc_fault}, {!f, f});
  endtask : acc
  // enables land at most two edges after their inputs; one spare edge
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  function automatic word_t gbit(input int i);
    return 32'h1 << (i < 8 ? i : (i == 8 ? 28 : 30));
  endfunction : gbit
  // ********
  // scenarios
  // ********
  task t_reset;
    check(unit_clk_en, 32'h0);
    rd_chk(`SLEEP_GATE_OFS, `GATE_RESET);
  endtask : t_reset
  task t_layout;
    wr(`SLEEP_GATE_OFS, 32'hffff_ffff);
    rd_chk(`SLEEP_GATE_OFS, 32'h5000_00ff);
    wr(12'h300, 32'h0);
    rd_chk(`SLEEP_GATE_OFS, 32'h5000_00ff);
    wr(`SLEEP_GATE_OFS, 32'h0);
    rd_chk(`SLEEP_GATE_OFS, 32'h0);
  endtask : t_layout
  task t_run_each;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk); run_q <= gbit(i);
      settle();
      check(unit_clk_en, 32'h1 << i);
      acc(unit_idx_t'(i), 1'b0);
      acc(unit_idx_t'((i + 1) % 10), 1'b1);
    end
    @(posedge clk); run_q <= 32'h0;
  endtask : t_run_each
  task t_modes;
    @(posedge clk); sel <= 1'b1; slp <= 1'b1; run_q <= 32'hffff_ffff;
    wr(`SLEEP_GATE_OFS, 32'h1000_0004);
    settle();
    check(unit_clk_en, 32'h104);
    rd_chk(`GATE_STATE_OFS, 32'h0000_0504);
    acc(4'h8, 1'b0);
    acc(4'h0, 1'b1);
    @(posedge clk); run_q <= 32'h0;
    settle();
    check(unit_clk_en, 32'h104);
    @(posedge clk); sel <= 1'b0; run_q <= 32'hffff_ffff;
    settle();
    check(unit_clk_en, 32'h3ff);
    @(posedge clk); sel <= 1'b1; deep <= 1'b1; deep_q <= 32'h4000_0080;
    settle();
    check(unit_clk_en, 32'h280);
    rd_chk(`GATE_STATE_OFS, 32'h0000_0a80);
    @(posedge clk); sel <= 1'b0; slp <= 1'b0; deep <= 1'b0; run_q <= 32'h0;
    settle();
  endtask : t_modes
  task t_irq;
    rd_chk(`IRQ_STATUS_OFS, 32'h3);
    wr(`IRQ_MASK_OFS, 32'h1);
    wr(`IRQ_STATUS_OFS, 32'h3);
    settle();
    check(irq, 32'h0);
    acc(4'hf, 1'b1);
    settle();
    check(irq, 32'h1);
    rd_chk(`IRQ_STATUS_OFS, 32'h1);
    rd_chk(`FAULT_INFO_OFS, 32'hf);
    wr(`IRQ_STATUS_OFS, 32'h1);
    settle();
    check(irq, 32'h0);
    wr(`IRQ_MASK_OFS, 32'h0);
    acc(4'h9, 1'b1);
    settle();
    check(irq, 32'h0);
    rd_chk(`IRQ_STATUS_OFS, 32'h1);
    rd_chk(`FAULT_INFO_OFS, 32'h9);
  endtask : t_irq
  task finish_test;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_layout();
    t_run_each();
    t_modes();
    t_irq();
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : sleep_mode_clock_gating_tb_top
